// *** logic/bmoc_pkg.sv ***
package bmoc_pkg;

    // Register offsets of the working register file
    localparam logic [11:0] ADDR_DROOP = 12'h250;
    localparam logic [11:0] ADDR_FSW = 12'h266;
    localparam logic [11:0] ADDR_COND = 12'h05c;
    localparam logic [11:0] ADDR_PINOVR = 12'h05e;
    localparam logic [11:0] ADDR_PROT = 12'h060;
    localparam logic [11:0] ADDR_LLCFG = 12'h06a;
    localparam logic [11:0] ADDR_TON_DELAY = 12'h270;
    localparam logic [11:0] ADDR_TON_RISE = 12'h271;
    localparam logic [11:0] ADDR_VOUT_TGT = 12'h272;
    localparam logic [11:0] ADDR_OC_LIMIT = 12'h273;
    localparam logic [11:0] ADDR_CAL_GAIN = 12'h274;
    localparam logic [11:0] ADDR_CAL_OFFS = 12'h275;
    localparam logic [11:0] ADDR_OC_RESP = 12'h276;
    localparam logic [11:0] ADDR_IOUT_STAT = 12'h277;
    localparam logic [11:0] ADDR_SEQ_STAT = 12'h278;

    // Field positions
    localparam int FCCM_BIT = 1;
    localparam int TON_OVR_BIT = 4;
    localparam int FCCM_OVR_BIT = 5;
    localparam int DOCP_FROM_AOCP_BIT = 3;
    localparam int AOCP_REG_SEL_BIT = 4;
    localparam int LL_RANGE_BIT = 6;
    localparam int STAT_OC_BIT = 0;
    localparam int STAT_AOCP_BIT = 1;

    // Reset values
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_FSW = 16'h0190;
    localparam logic [15:0] RST_CAL_GAIN = 16'h0400;
    localparam logic [15:0] RST_OC_LIMIT = 16'hffff;

    // Droop code ceilings: 10 mohm / 19.53 uohm and 50 mohm / 100 uohm
    localparam logic [15:0] DROOP_MAX_FINE = 16'h0200;
    localparam logic [15:0] DROOP_MAX_WIDE = 16'h01f4;

    // Overcurrent event counting
    localparam logic [3:0] AOCP_TRIP_COUNT = 4'ha;
    localparam logic [1:0] AOCP_QUIET_COUNT = 2'h3;

    // Calibration gain has ten fraction bits
    localparam int CAL_GAIN_FRAC = 10;

    // Fault responses
    localparam logic [1:0] RESP_SHUTDOWN = 2'h0;
    localparam logic [1:0] RESP_LATCH = 2'h1;
    localparam logic [1:0] RESP_RETRY = 2'h2;

    // Timing
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int TIME_UNIT_US = 1000;
    localparam int MS_CYCLES = CLK_FREQ_HZ / 1_000_000 * TIME_UNIT_US;
    localparam logic [15:0] RETRY_MS = 16'h0008;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_OFF = 5'b00001,
        ST_DELAY = 5'b00010,
        ST_RAMP = 5'b00100,
        ST_RUN = 5'b01000,
        ST_FAULT = 5'b10000
    } bmoc_state_t;

    // Power stage signals seen by the block
    typedef struct packed {
        logic pwm_req;
        logic valley_pt;
        logic fast_oc;
    } bmoc_stage_in_t;

    // Load-line settings handed to the analog loop
    typedef struct packed {
        logic range_wide;
        logic [15:0] droop;
        logic [3:0] bandwidth;
    } bmoc_loadline_t;

endpackage

// *** logic/bmoc_top.sv ***
`timescale 1ns/1ns
module bmoc_top #(
    parameter int MS_CYCLES = bmoc_pkg::MS_CYCLES,
    parameter int FILT_SHIFT = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enable_in,
    input wire logic [3:0] ton_mode_strap,
    input wire logic [2:0] current_limit_strap,
    input wire bmoc_pkg::bmoc_stage_in_t stage_in,
    input wire logic [15:0] avg_current,
    input wire logic avg_valid,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic switching_en,
    output logic diode_emulation_mode,
    output logic [2:0] fsw_code,
    output logic [15:0] vref_out,
    output bmoc_pkg::bmoc_loadline_t loadline,
    output logic [2:0] aocp_thresh,
    output logic hs_start,
    output logic ls_hold,
    output logic oc_fault
);

    // Kilohertz value to frequency code; 1600 has no code
    function automatic logic [3:0] fsw_decode(input logic [15:0] khz);
        unique case (khz)
            16'h0190: fsw_decode = 4'h8;
            16'h0258: fsw_decode = 4'h9;
            16'h0320: fsw_decode = 4'ha;
            16'h03e8: fsw_decode = 4'hb;
            16'h04b0: fsw_decode = 4'hc;
            16'h0578: fsw_decode = 4'hd;
            16'h0708: fsw_decode = 4'he;
            16'h07d0: fsw_decode = 4'hf;
            default: fsw_decode = 4'h0;
        endcase
    endfunction

    // Working registers written by the host
    logic [15:0] droop_reg, fsw_reg, cond_reg, pinovr_reg, prot_reg;
    logic [15:0] llcfg_reg, ton_delay_reg, ton_rise_reg, vout_tgt_reg;
    logic [15:0] oc_limit_reg, cal_gain_reg, cal_offs_reg, oc_resp_reg;
    logic [1:0] iout_stat_reg;

    // Settings frozen while the output runs
    logic fccm_lat_reg;
    logic [2:0] fsw_lat_reg;
    logic [3:0] strap_lat_reg;
    logic [2:0] current_limit_strap_lat_reg;
    logic init_reg;

    // Sequencer
    bmoc_pkg::bmoc_state_t state_reg, state_next;
    logic [$clog2(MS_CYCLES)-1:0] tick_cnt_reg;
    logic [15:0] elapsed_reg;
    logic [15:0] vref_reg;

    // Pulse gating and event counting
    logic fast_oc_d_reg, skip_pend_reg, hs_start_reg, ls_hold_reg;
    logic oc_seen_reg;
    logic [3:0] oc_cnt_reg;
    logic [1:0] quiet_reg;

    // Averaged current path
    logic [23:0] filt_reg;
    logic filt_new_reg;
    logic [15:0] rdata_reg;

    // Address decode
    wire wr_droop = reg_wr && reg_addr == bmoc_pkg::ADDR_DROOP;
    wire wr_fsw = reg_wr && reg_addr == bmoc_pkg::ADDR_FSW;
    wire wr_cond = reg_wr && reg_addr == bmoc_pkg::ADDR_COND;
    wire wr_pinovr = reg_wr && reg_addr == bmoc_pkg::ADDR_PINOVR;
    wire wr_prot = reg_wr && reg_addr == bmoc_pkg::ADDR_PROT;
    wire wr_llcfg = reg_wr && reg_addr == bmoc_pkg::ADDR_LLCFG;
    wire wr_tdly = reg_wr && reg_addr == bmoc_pkg::ADDR_TON_DELAY;
    wire wr_trise = reg_wr && reg_addr == bmoc_pkg::ADDR_TON_RISE;
    wire wr_vtgt = reg_wr && reg_addr == bmoc_pkg::ADDR_VOUT_TGT;
    wire wr_oclim = reg_wr && reg_addr == bmoc_pkg::ADDR_OC_LIMIT;
    wire wr_gain = reg_wr && reg_addr == bmoc_pkg::ADDR_CAL_GAIN;
    wire wr_offs = reg_wr && reg_addr == bmoc_pkg::ADDR_CAL_OFFS;
    wire wr_resp = reg_wr && reg_addr == bmoc_pkg::ADDR_OC_RESP;
    wire wr_stat = reg_wr && reg_addr == bmoc_pkg::ADDR_IOUT_STAT;

    // State decode
    wire st_off = state_reg == bmoc_pkg::ST_OFF;
    wire st_ramp = state_reg == bmoc_pkg::ST_RAMP;
    wire st_run = state_reg == bmoc_pkg::ST_RUN;
    wire st_fault = state_reg == bmoc_pkg::ST_FAULT;
    wire switching = st_ramp || st_run;
    wire ms_tick = tick_cnt_reg == ($clog2(MS_CYCLES))'(MS_CYCLES - 1);
    wire state_change = state_next != state_reg;

    // pin straps only when neither override bit is set
    wire use_strap = !pinovr_reg[bmoc_pkg::TON_OVR_BIT] &&
        !pinovr_reg[bmoc_pkg::FCCM_OVR_BIT];
    // eight legal frequencies; an illegal value keeps the old code
    wire [3:0] fsw_dec = fsw_decode(fsw_reg);
    wire [2:0] fsw_pick = use_strap ? strap_lat_reg[2:0] :
        (fsw_dec[3] ? fsw_dec[2:0] : fsw_lat_reg);
    wire fccm_pick = use_strap ? strap_lat_reg[3] :
        cond_reg[bmoc_pkg::FCCM_BIT];
    // start of a run is the only moment settings are taken
    wire start_run = st_off && state_next == bmoc_pkg::ST_DELAY;

    // Fast overcurrent edge
    wire oc_rise = stage_in.fast_oc && !fast_oc_d_reg;
    // block while over limit or after a crossing
    wire hs_block = stage_in.fast_oc || skip_pend_reg;

    // event in this cycle as seen at the valley
    wire oc_event = oc_seen_reg || stage_in.fast_oc;
    wire [3:0] oc_cnt_inc = oc_cnt_reg + 4'h1;
    wire [1:0] quiet_inc = quiet_reg + 2'h1;
    wire aocp_trip = switching && stage_in.valley_pt && oc_event &&
        oc_cnt_inc == bmoc_pkg::AOCP_TRIP_COUNT &&
        prot_reg[bmoc_pkg::DOCP_FROM_AOCP_BIT];

    // first-order low-pass; shift sets corner against sample rate
    wire signed [24:0] filt_err = $signed({1'b0, avg_current, 8'h00}) -
        $signed({1'b0, filt_reg});
    wire signed [24:0] filt_step = filt_err >>> FILT_SHIFT;
    wire [23:0] filt_sum = 24'($signed({1'b0, filt_reg}) + filt_step);
    // gain with ten fraction bits, signed offset
    wire [31:0] gained = filt_reg[23:8] * cal_gain_reg;
    wire signed [17:0] calib = $signed({2'b00,
        gained[bmoc_pkg::CAL_GAIN_FRAC +: 16]}) +
        $signed({{2{cal_offs_reg[15]}}, cal_offs_reg});
    wire docp_trip = switching && filt_new_reg &&
        calib > $signed({2'b00, oc_limit_reg});
    wire fault_hit = docp_trip || aocp_trip;

    // reference in proportion to elapsed time over rise time
    wire [31:0] ramp_prod = vout_tgt_reg * elapsed_reg;
    wire [15:0] ramp_ref = ton_rise_reg == bmoc_pkg::RST_ZERO ?
        vout_tgt_reg : 16'(ramp_prod / 32'(ton_rise_reg));
    wire [15:0] vref_next = st_ramp ? ramp_ref :
        (st_run ? vout_tgt_reg : bmoc_pkg::RST_ZERO);

    // droop clamped to the span of the chosen range
    wire ll_wide = llcfg_reg[bmoc_pkg::LL_RANGE_BIT];
    wire [15:0] droop_max = ll_wide ? bmoc_pkg::DROOP_MAX_WIDE :
        bmoc_pkg::DROOP_MAX_FINE;
    wire [15:0] droop_eff = droop_reg > droop_max ? droop_max : droop_reg;

    // Read mux; unmapped offsets read zero
    logic [15:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            bmoc_pkg::ADDR_DROOP: rd_mux = droop_reg;
            bmoc_pkg::ADDR_FSW: rd_mux = fsw_reg;
            bmoc_pkg::ADDR_COND: rd_mux = cond_reg;
            bmoc_pkg::ADDR_PINOVR: rd_mux = pinovr_reg;
            bmoc_pkg::ADDR_PROT: rd_mux = prot_reg;
            bmoc_pkg::ADDR_LLCFG: rd_mux = llcfg_reg;
            bmoc_pkg::ADDR_TON_DELAY: rd_mux = ton_delay_reg;
            bmoc_pkg::ADDR_TON_RISE: rd_mux = ton_rise_reg;
            bmoc_pkg::ADDR_VOUT_TGT: rd_mux = vout_tgt_reg;
            bmoc_pkg::ADDR_OC_LIMIT: rd_mux = oc_limit_reg;
            bmoc_pkg::ADDR_CAL_GAIN: rd_mux = cal_gain_reg;
            bmoc_pkg::ADDR_CAL_OFFS: rd_mux = cal_offs_reg;
            bmoc_pkg::ADDR_OC_RESP: rd_mux = oc_resp_reg;
            bmoc_pkg::ADDR_IOUT_STAT: rd_mux = {14'h0000, iout_stat_reg};
            bmoc_pkg::ADDR_SEQ_STAT: rd_mux = {11'h000, state_reg};
            default: rd_mux = bmoc_pkg::RST_ZERO;
        endcase
    end

    // Host-written registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            droop_reg <= bmoc_pkg::RST_ZERO;
            fsw_reg <= bmoc_pkg::RST_FSW;
            cond_reg <= bmoc_pkg::RST_ZERO;
            pinovr_reg <= bmoc_pkg::RST_ZERO;
            prot_reg <= bmoc_pkg::RST_ZERO;
            llcfg_reg <= bmoc_pkg::RST_ZERO;
            ton_delay_reg <= bmoc_pkg::RST_ZERO;
            ton_rise_reg <= bmoc_pkg::RST_ZERO;
            vout_tgt_reg <= bmoc_pkg::RST_ZERO;
            oc_limit_reg <= bmoc_pkg::RST_OC_LIMIT;
            cal_gain_reg <= bmoc_pkg::RST_CAL_GAIN;
            cal_offs_reg <= bmoc_pkg::RST_ZERO;
            oc_resp_reg <= bmoc_pkg::RST_ZERO;
        end else begin
            if (wr_droop) droop_reg <= reg_wdata;
            if (wr_fsw) fsw_reg <= reg_wdata;
            if (wr_cond) cond_reg <= reg_wdata;
            if (wr_pinovr) pinovr_reg <= reg_wdata;
            if (wr_prot) prot_reg <= reg_wdata;
            if (wr_llcfg) llcfg_reg <= reg_wdata;
            if (wr_tdly) ton_delay_reg <= reg_wdata;
            if (wr_trise) ton_rise_reg <= reg_wdata;
            if (wr_vtgt) vout_tgt_reg <= reg_wdata;
            if (wr_oclim) oc_limit_reg <= reg_wdata;
            if (wr_gain) cal_gain_reg <= reg_wdata;
            if (wr_offs) cal_offs_reg <= reg_wdata;
            if (wr_resp) oc_resp_reg <= reg_wdata;
        end
    end

    // sticky status; a new fault beats a write-one clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            iout_stat_reg <= 2'h0;
        end else begin
            iout_stat_reg <= (iout_stat_reg & ~({2{wr_stat}} &
                reg_wdata[1:0])) | {aocp_trip, fault_hit};
        end
    end

    // Read data registered, one cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) rdata_reg <= bmoc_pkg::RST_ZERO;
        else if (reg_rd) rdata_reg <= rd_mux;
    end

    // straps follow the pins only while off, so a run holds them
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            init_reg <= 1'b1;
            strap_lat_reg <= 4'h0;
            current_limit_strap_lat_reg <= 3'h0;
        end else begin
            init_reg <= 1'b0;
            if (init_reg || st_off) begin
                strap_lat_reg <= ton_mode_strap;
                current_limit_strap_lat_reg <= current_limit_strap;
            end
        end
    end

    // mode and frequency frozen for the whole run
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fccm_lat_reg <= 1'b0;
            fsw_lat_reg <= 3'h0;
        end else if (start_run) begin
            fccm_lat_reg <= fccm_pick;
            fsw_lat_reg <= fsw_pick;
        end
    end

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            bmoc_pkg::ST_OFF: begin
                if (enable_in && !init_reg) state_next = bmoc_pkg::ST_DELAY;
            end
            bmoc_pkg::ST_DELAY: begin
                // ramp waits for the full delay
                if (!enable_in) state_next = bmoc_pkg::ST_OFF;
                else if (elapsed_reg >= ton_delay_reg)
                    state_next = bmoc_pkg::ST_RAMP;
            end
            bmoc_pkg::ST_RAMP, bmoc_pkg::ST_RUN: begin
                // fault takes priority over the ramp end
                if (!enable_in) state_next = bmoc_pkg::ST_OFF;
                else if (fault_hit) state_next = bmoc_pkg::ST_FAULT;
                else if (st_ramp && elapsed_reg >= ton_rise_reg)
                    state_next = bmoc_pkg::ST_RUN;
            end
            bmoc_pkg::ST_FAULT: begin
                // shutdown waits for enable low, latch waits reset
                if (oc_resp_reg[1:0] == bmoc_pkg::RESP_RETRY) begin
                    if (!enable_in) state_next = bmoc_pkg::ST_OFF;
                    else if (elapsed_reg >= bmoc_pkg::RETRY_MS)
                        state_next = bmoc_pkg::ST_DELAY;
                end else if (oc_resp_reg[1:0] != bmoc_pkg::RESP_LATCH &&
                    !enable_in) begin
                    state_next = bmoc_pkg::ST_OFF;
                end
            end
            default: state_next = bmoc_pkg::ST_OFF;
        endcase
    end

    // State, millisecond tick and elapsed time restart on each entry
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= bmoc_pkg::ST_OFF;
            tick_cnt_reg <= '0;
            elapsed_reg <= bmoc_pkg::RST_ZERO;
        end else begin
            state_reg <= state_next;
            if (state_change || st_off || ms_tick) tick_cnt_reg <= '0;
            else tick_cnt_reg <= tick_cnt_reg + 1'b1;
            if (state_change || st_off) elapsed_reg <= bmoc_pkg::RST_ZERO;
            else if (ms_tick) elapsed_reg <= elapsed_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) vref_reg <= bmoc_pkg::RST_ZERO;
        else vref_reg <= vref_next;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fast_oc_d_reg <= 1'b0;
            skip_pend_reg <= 1'b0;
            hs_start_reg <= 1'b0;
            ls_hold_reg <= 1'b0;
        end else begin
            fast_oc_d_reg <= stage_in.fast_oc;
            hs_start_reg <= switching && stage_in.pwm_req && !hs_block;
            // Crossing arms a skip; the next pulse request consumes it
            if (switching && oc_rise) skip_pend_reg <= 1'b1;
            else if (stage_in.pwm_req || !switching) skip_pend_reg <= 1'b0;
            // Low side held on until the next cycle starts
            if (switching && oc_rise) ls_hold_reg <= 1'b1;
            else if (stage_in.pwm_req || !switching) ls_hold_reg <= 1'b0;
        end
    end

    // event counter evaluated at each valley
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oc_seen_reg <= 1'b0;
            oc_cnt_reg <= 4'h0;
            quiet_reg <= 2'h0;
        end else if (!switching) begin
            oc_seen_reg <= 1'b0;
            oc_cnt_reg <= 4'h0;
            quiet_reg <= 2'h0;
        end else if (stage_in.valley_pt) begin
            oc_seen_reg <= oc_rise;
            if (oc_event) begin
                oc_cnt_reg <= aocp_trip ? 4'h0 : oc_cnt_inc;
                quiet_reg <= 2'h0;
            end else if (quiet_inc == bmoc_pkg::AOCP_QUIET_COUNT) begin
                oc_cnt_reg <= 4'h0;
                quiet_reg <= 2'h0;
            end else begin
                quiet_reg <= quiet_inc;
            end
        end else if (oc_rise) begin
            oc_seen_reg <= 1'b1;
        end
    end

    // filter updates on each averaged sample
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            filt_reg <= 24'h000000;
            filt_new_reg <= 1'b0;
        end else begin
            filt_new_reg <= avg_valid;
            if (avg_valid) filt_reg <= filt_sum;
        end
    end

    assign reg_rdata = rdata_reg;
    assign switching_en = switching;
    assign diode_emulation_mode = !fccm_lat_reg;
    assign fsw_code = fsw_lat_reg;
    assign vref_out = vref_reg;
    assign loadline = '{range_wide: ll_wide, droop: droop_eff,
        bandwidth: llcfg_reg[3:0]};
    assign aocp_thresh = prot_reg[bmoc_pkg::AOCP_REG_SEL_BIT] ?
        prot_reg[2:0] : current_limit_strap_lat_reg;
    assign hs_start = hs_start_reg;
    assign ls_hold = ls_hold_reg;
    assign oc_fault = st_fault;

endmodule

// *** test/bmoc_assertions.sv ***
`timescale 1ns/1ns
// Gating, hold and clamp relations seen at the block's ports
module bmoc_checker #(
    parameter int MS_CYCLES = 10,
    parameter int FILT_SHIFT = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire bmoc_pkg::bmoc_stage_in_t stage_in,
    input wire logic switching_en,
    input wire logic diode_emulation_mode,
    input wire logic [2:0] fsw_code,
    input wire bmoc_pkg::bmoc_loadline_t loadline,
    input wire logic hs_start,
    input wire logic ls_hold,
    input wire logic oc_fault
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    hs_clean_req_a: assert property (
        hs_start |-> $past(stage_in.pwm_req) && !$past(stage_in.fast_oc))
        else $error("High-side pulse without a clean request");
    hs_after_skip_a: assert property (
        hs_start |-> !$past(ls_hold))
        else $error("High-side pulse while a skip was pending");
    // A pulse in the same cycle as the crossing is handled by the skip
    ls_hold_set_a: assert property (
        $rose(stage_in.fast_oc) && switching_en && !stage_in.pwm_req
        |=> ls_hold) else $error("Low side not held after crossing");
    hs_when_on_a: assert property (
        hs_start |-> $past(switching_en))
        else $error("High-side pulse while stage is off");
    mode_held_a: assert property (
        switching_en && $past(switching_en) |-> $stable(diode_emulation_mode))
        else $error("Conduction mode changed while running");
    freq_held_a: assert property (
        switching_en && $past(switching_en) |-> $stable(fsw_code))
        else $error("Frequency code changed while running");
    droop_clamp_a: assert property (
        loadline.droop <= (loadline.range_wide ? bmoc_pkg::DROOP_MAX_WIDE
        : bmoc_pkg::DROOP_MAX_FINE)) else $error("Droop above its range");
    fault_stops_a: assert property (
        oc_fault |-> !switching_en) else $error("Switching during fault");
endmodule

bind bmoc_top bmoc_checker #(.MS_CYCLES(MS_CYCLES), .FILT_SHIFT(FILT_SHIFT))
    chk (.clk, .reset_n, .stage_in, .switching_en, .diode_emulation_mode,
    .fsw_code, .loadline, .hs_start, .ls_hold, .oc_fault);

// *** test/bmoc_stage_model.sv ***
`timescale 1ns/1ns
// Power stage: fixed eight-cycle period, overload drives the comparator
module bmoc_stage_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic overload,
    output bmoc_pkg::bmoc_stage_in_t stage_in
);
    logic [2:0] phase_reg;
    // Free-running phase so valleys and requests never coincide
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg <= 3'h0;
        end else begin
            phase_reg <= phase_reg + 3'h1;
        end
    end
    assign stage_in.pwm_req = (phase_reg == 3'h0);
    assign stage_in.valley_pt = (phase_reg == 3'h4);
    assign stage_in.fast_oc = overload;
endmodule

// *** test/buck_mode_and_overcurrent_control_bench.sv ***
`timescale 1ns/1ns
// Strap, stage and register traffic into the control block
module buck_mode_and_overcurrent_control_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic enable_in = 1'b0;
    logic [3:0] ton_mode_strap = 4'hd;
    logic [2:0] current_limit_strap = 3'h6;
    logic overload = 1'b0;
    logic [15:0] avg_current = 16'h0200;
    logic avg_valid = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, vref_out, rv;
    logic switching_en, diode_emulation_mode, hs_start, ls_hold, oc_fault;
    logic [2:0] fsw_code, aocp_thresh;
    bmoc_pkg::bmoc_stage_in_t stage_in;
    bmoc_pkg::bmoc_loadline_t loadline;
    int bad_count = 0;
    int num_checks = 0;
    int hc;
    always #10 clk = ~clk;
    bmoc_stage_model stage (.clk, .reset_n, .overload, .stage_in);
    // Short millisecond keeps the sequencing run brief
    bmoc_top #(.MS_CYCLES(10), .FILT_SHIFT(4)) uut (.clk, .reset_n,
        .enable_in, .ton_mode_strap, .current_limit_strap, .stage_in,
        .avg_current, .avg_valid, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .switching_en, .diode_emulation_mode, .fsw_code,
        .vref_out, .loadline, .aocp_thresh, .hs_start, .ls_hold, .oc_fault);
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data is taken one cycle after the strobe is sampled
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        rv = reg_rdata;
    endtask
    task automatic cyc_en(input int n);
        @(posedge clk);
        enable_in <= 1'b0;
        tick(4);
        enable_in <= 1'b1;
        tick(n);
    endtask
    task automatic valleys(input int n);
        repeat (n) begin
            @(posedge clk);
            while (stage_in.valley_pt !== 1'b1) @(posedge clk);
        end
    endtask
    task automatic samp(input int n);
        repeat (n) begin
            @(posedge clk);
            avg_valid <= 1'b1;
            @(posedge clk);
            avg_valid <= 1'b0;
        end
        tick(3);
    endtask
    task automatic t_regs();
        rd(bmoc_pkg::ADDR_FSW);
        chk("fsw reset", rv, bmoc_pkg::RST_FSW);
        rd(bmoc_pkg::ADDR_CAL_GAIN);
        chk("gain reset", rv, bmoc_pkg::RST_CAL_GAIN);
        wr(12'h123, 16'h5a5a);
        rd(12'h123);
        chk("unmapped", rv, 16'h0000);
        chk("thr strap", 16'(aocp_thresh), 16'h0006);
        wr(bmoc_pkg::ADDR_PROT, 16'h0015);
        tick(2);
        chk("thr reg", 16'(aocp_thresh), 16'h0005);
        wr(bmoc_pkg::ADDR_PROT, 16'h0000);
        wr(bmoc_pkg::ADDR_DROOP, 16'hffff);
        tick(2);
        chk("droop fine", loadline.droop, 16'h0200);
        wr(bmoc_pkg::ADDR_LLCFG, 16'h004f);
        tick(2);
        chk("droop wide", loadline.droop, 16'h01f4);
        chk("bandwidth", 16'(loadline.bandwidth), 16'h000f);
    endtask
    task automatic t_mode();
        cyc_en(4);
        chk("strap fsw", 16'(fsw_code), 16'h0005);
        chk("strap mode", 16'(diode_emulation_mode), 16'h0000);
        ton_mode_strap <= 4'h2;
        tick(4);
        chk("strap held", 16'(fsw_code), 16'h0005);
        cyc_en(4);
        chk("strap new", 16'(fsw_code), 16'h0002);
        chk("dem strap", 16'(diode_emulation_mode), 16'h0001);
        wr(bmoc_pkg::ADDR_COND, 16'h0002);
        wr(bmoc_pkg::ADDR_FSW, 16'h07d0);
        cyc_en(4);
        chk("no override", 16'(fsw_code), 16'h0002);
        wr(bmoc_pkg::ADDR_PINOVR, 16'h0030);
        tick(4);
        chk("mode held", 16'(diode_emulation_mode), 16'h0001);
        cyc_en(4);
        chk("fccm", 16'(diode_emulation_mode), 16'h0000);
        // 1600 kHz is refused, so the previous code stays
        for (int i = 0; i < 9; i++) begin
            wr(bmoc_pkg::ADDR_FSW, 16'(400 + 200 * i));
            cyc_en(4);
            chk("fsw code", 16'(fsw_code), 16'(i - (i >= 6)));
        end
    endtask
    task automatic t_seq();
        @(posedge clk);
        enable_in <= 1'b0;
        wr(bmoc_pkg::ADDR_TON_DELAY, 16'h0002);
        wr(bmoc_pkg::ADDR_TON_RISE, 16'h0004);
        wr(bmoc_pkg::ADDR_VOUT_TGT, 16'h0800);
        enable_in <= 1'b1;
        tick(15);
        chk("in delay", 16'(switching_en), 16'h0000);
        tick(40);
        chk("ramping", 16'(vref_out < 16'h0800), 16'h0001);
        chk("ramp on", 16'(switching_en), 16'h0001);
        tick(30);
        chk("vref end", vref_out, 16'h0800);
        rd(bmoc_pkg::ADDR_SEQ_STAT);
        chk("run state", rv, 16'(bmoc_pkg::ST_RUN));
    endtask
    task automatic t_gate();
        valleys(1);
        overload <= 1'b1;
        tick(2);
        chk("ls hold", 16'(ls_hold), 16'h0001);
        hc = 0;
        repeat (32) begin
            @(posedge clk);
            hc += (hs_start === 1'b1);
        end
        chk("hs blocked", 16'(hc), 16'h0000);
        valleys(1);
        overload <= 1'b0;
        hc = 0;
        repeat (16) begin
            @(posedge clk);
            hc += (hs_start === 1'b1);
        end
        chk("hs resumed", 16'(hc), 16'h0002);
    endtask
    task automatic t_count();
        wr(bmoc_pkg::ADDR_PROT, 16'h0008);
        wr(bmoc_pkg::ADDR_OC_RESP, 16'(bmoc_pkg::RESP_SHUTDOWN));
        valleys(4);
        overload <= 1'b1;
        valleys(9);
        overload <= 1'b0;
        valleys(3);
        overload <= 1'b1;
        valleys(9);
        tick(2);
        chk("nine events", 16'(oc_fault), 16'h0000);
        valleys(1);
        tick(2);
        chk("ten events", 16'(oc_fault), 16'h0001);
        overload <= 1'b0;
        rd(bmoc_pkg::ADDR_IOUT_STAT);
        chk("trip flag", 16'(rv[bmoc_pkg::STAT_AOCP_BIT]), 16'h0001);
        enable_in <= 1'b0;
        tick(4);
        chk("shutdown", 16'(oc_fault), 16'h0000);
        wr(bmoc_pkg::ADDR_IOUT_STAT, 16'h0003);
        rd(bmoc_pkg::ADDR_IOUT_STAT);
        chk("cleared", rv, 16'h0000);
        wr(bmoc_pkg::ADDR_PROT, 16'h0000);
    endtask
    task automatic t_avg();
        wr(bmoc_pkg::ADDR_OC_LIMIT, 16'h00ff);
        wr(bmoc_pkg::ADDR_OC_RESP, 16'(bmoc_pkg::RESP_LATCH));
        cyc_en(100);
        samp(1);
        chk("filtered", 16'(oc_fault), 16'h0000);
        wr(bmoc_pkg::ADDR_CAL_GAIN, 16'h0200);
        cyc_en(100);
        samp(48);
        chk("half gain", 16'(oc_fault), 16'h0000);
        wr(bmoc_pkg::ADDR_CAL_GAIN, 16'h0400);
        cyc_en(100);
        samp(48);
        chk("avg trip", 16'(oc_fault), 16'h0001);
        enable_in <= 1'b0;
        tick(4);
        chk("latched", 16'(oc_fault), 16'h0001);
        rd(bmoc_pkg::ADDR_IOUT_STAT);
        chk("avg flag", 16'(rv[bmoc_pkg::STAT_OC_BIT]), 16'h0001);
    endtask
    task automatic conclude();
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Run takes some 1100 cycles; the limit leaves wide margin
    initial begin
        #400_000;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        tick(2);
        t_regs();
        t_mode();
        t_seq();
        t_gate();
        t_count();
        t_avg();
        conclude();
    end
endmodule
